// ### shared/lock_regs_pkg.sv
/*
  Constants for the serdes lock and link reset register group: register
  addresses, field positions, reset values and serial frame layout.
  Assumes a 24-bit serial control frame: one read flag, 15 address bits,
  8 data bits, most significant bit first.
*/
package lock_regs_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int SHIFT_W = 23;
  localparam int NUM_PLL = 4;
  localparam int NUM_LANES = 16;
  localparam int ARR_W = 4;
  localparam int SYNC_W = 7;

  localparam logic [ADDR_W-1:0] ADDR_LOCK_STATUS = 15'h0250;
  localparam logic [ADDR_W-1:0] ADDR_LINK_RESET = 15'h0253;
  localparam logic [ADDR_W-1:0] ADDR_VREF_SELECT = 15'h02B0;
  localparam logic [ADDR_W-1:0] ADDR_CUR_DOUBLER = 15'h02B1;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [NUM_PLL-1:0] LOST_RESET = 4'h0;
  localparam logic [NUM_PLL-1:0] LOST_NONE = 4'h0;
  localparam int HOLD_BIT = 0;
  localparam int VREF_BIT = 0;
  localparam int DOUBLER_BIT = 0;

  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] HDR_BITS = 5'h10;
  localparam logic [CNT_W-1:0] HDR_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;

  // synchroniser order {clk, select_n, data, lock[3:0]}; select and lock idle high
  // so that leaving reset raises no false loss of lock
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h2F;
endpackage

// ### logic/pin_filter.sv
/*
  Three-stage input synchroniser with agreement filter: the output level
  follows only when the second and third stages agree.
  Assumes inputs are asynchronous to clock_in.
*/
`timescale 1ns/1ns
module pin_filter
  import lock_regs_pkg::*;
#(
  parameter int W = SYNC_W,
  parameter logic [SYNC_W-1:0] RESET_VAL = SYNC_RESET
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
      always_comb
      begin
        lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
      end
      always_ff @(posedge clock_in)
      begin
        if (reset_in)
        begin
          s1_r <= RESET_VAL[i];
          s2_r <= RESET_VAL[i];
          s3_r <= RESET_VAL[i];
          lvl_r <= RESET_VAL[i];
        end
        else
        begin
          s1_r <= pins_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          lvl_r <= lvl_nxt;
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate
endmodule

// ### logic/lock_link_regs.sv
/*
  Serdes lock status, link digital reset, reference select and current
  doubler registers behind the serial control port, plus the one-shot
  lane arrival capture gated by the link digital reset.
  Assumes serial pins and pll lock lines are asynchronous; release attempts
  and arrival values come from logic on clock_in.
*/
`timescale 1ns/1ns
module lock_link_regs
  import lock_regs_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic spi_clk_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_oe_out,
  input wire logic [NUM_PLL-1:0] serdes_lock_live_in,
  input wire logic buffer_release_try_in,
  input wire logic [NUM_LANES*ARR_W-1:0] lane_arrival_in,
  output logic link_digital_hold_out,
  output logic outside_vref_select_out,
  output logic output_current_doubler_bit_out,
  output logic [NUM_LANES*ARR_W-1:0] lane_arrival_capture_out,
  output logic lane_arrival_valid_out
);
  logic [SYNC_W-1:0] lvl;
  logic sclk, sel_n, sdi;
  logic [NUM_PLL-1:0] lock;

  pin_filter #(.W(SYNC_W), .RESET_VAL(SYNC_RESET)) u_filter (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .pins_in({spi_clk_in, spi_sel_n_in, spi_data_in, serdes_lock_live_in}),
    .level_out(lvl)
  );
  assign sclk = lvl[6];
  assign sel_n = lvl[5];
  assign sdi = lvl[4];
  assign lock = lvl[3:0];

  logic sclk_prev_r, sclk_prev_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [SHIFT_W-1:0] shift_r, shift_nxt;
  logic rw_r, rw_nxt;
  logic [DATA_W-1:0] tx_r, tx_nxt;
  logic sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic rise, fall, wr_fire;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] wr_data, rd_data;

  logic [NUM_PLL-1:0] lost_r, lost_nxt, w1c;
  logic [DATA_W-1:0] hold_r, hold_nxt, vref_r, vref_nxt, dbl_r, dbl_nxt;

  logic armed_r, armed_nxt, valid_r, valid_nxt;
  logic [NUM_LANES*ARR_W-1:0] cap_r, cap_nxt;

  assign rise = sclk & ~sclk_prev_r;
  assign fall = ~sclk & sclk_prev_r;
  assign rd_addr = {shift_r[ADDR_W-2:0], sdi};
  assign wr_addr = shift_r[SHIFT_W-2 -: ADDR_W];
  assign wr_data = {shift_r[DATA_W-2:0], sdi};
  assign wr_fire = ~sel_n & rise & (cnt_r == FRAME_LAST) & ~rw_r;

  // read view of the register group
  always_comb
  begin
    unique case (rd_addr)
      ADDR_LOCK_STATUS: rd_data = {lock, lost_r};
      ADDR_LINK_RESET: rd_data = hold_r;
      ADDR_VREF_SELECT: rd_data = vref_r;
      ADDR_CUR_DOUBLER: rd_data = dbl_r;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  // serial frame: sample on rising clock, drive read data on falling clock
  always_comb
  begin
    sclk_prev_nxt = sclk;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    rw_nxt = rw_r;
    tx_nxt = tx_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    if (sel_n)
    begin
      cnt_nxt = CNT_ZERO;
      oe_nxt = 1'b0;
    end
    else
    begin
      if (rise && cnt_r < FRAME_BITS)
      begin
        shift_nxt = {shift_r[SHIFT_W-2:0], sdi};
        cnt_nxt = cnt_r + CNT_ONE;
        if (cnt_r == CNT_ZERO)
          rw_nxt = sdi;
        if (cnt_r == HDR_LAST)
          tx_nxt = rd_data;
      end
      if (fall && rw_r && cnt_r >= HDR_BITS && cnt_r <= FRAME_BITS)
      begin
        if (cnt_r < FRAME_BITS)
        begin
          sdo_nxt = tx_r[DATA_W-1];
          tx_nxt = {tx_r[DATA_W-2:0], 1'b0};
        end
        oe_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      sclk_prev_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      shift_r <= '0;
      rw_r <= 1'b0;
      tx_r <= REG_RESET;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= sclk_prev_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      rw_r <= rw_nxt;
      tx_r <= tx_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // register writes and sticky lock loss
  always_comb
  begin
    hold_nxt = hold_r;
    vref_nxt = vref_r;
    dbl_nxt = dbl_r;
    w1c = LOST_NONE;
    if (wr_fire)
    begin
      unique case (wr_addr)
        ADDR_LOCK_STATUS: w1c = wr_data[NUM_PLL-1:0];
        ADDR_LINK_RESET: hold_nxt = wr_data;
        ADDR_VREF_SELECT: vref_nxt = wr_data;
        ADDR_CUR_DOUBLER: dbl_nxt = wr_data;
        default: w1c = LOST_NONE;
      endcase
    end
    lost_nxt = (lost_r & ~w1c) | ~lock;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      lost_r <= LOST_RESET;
      hold_r <= REG_RESET;
      vref_r <= REG_RESET;
      dbl_r <= REG_RESET;
    end
    else
    begin
      lost_r <= lost_nxt;
      hold_r <= hold_nxt;
      vref_r <= vref_nxt;
      dbl_r <= dbl_nxt;
    end
  end

  // one-shot arrival capture, re-armed while the link logic is held
  always_comb
  begin
    armed_nxt = armed_r;
    valid_nxt = valid_r;
    cap_nxt = cap_r;
    if (hold_r[HOLD_BIT])
    begin
      armed_nxt = 1'b1;
      valid_nxt = 1'b0;
    end
    else if (armed_r && buffer_release_try_in)
    begin
      cap_nxt = lane_arrival_in;
      armed_nxt = 1'b0;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      armed_r <= 1'b1;
      valid_r <= 1'b0;
      cap_r <= '0;
    end
    else
    begin
      armed_r <= armed_nxt;
      valid_r <= valid_nxt;
      cap_r <= cap_nxt;
    end
  end

  assign spi_data_out = sdo_r;
  assign spi_data_oe_out = oe_r;
  assign link_digital_hold_out = hold_r[HOLD_BIT];
  assign outside_vref_select_out = vref_r[VREF_BIT];
  assign output_current_doubler_bit_out = dbl_r[DOUBLER_BIT];
  assign lane_arrival_capture_out = cap_r;
  assign lane_arrival_valid_out = valid_r;
endmodule

// ### bench/lock_link_properties.sv
/* port assertions for lock_link_regs
   assumes one clock domain, bound to every lock_link_regs */
`timescale 1ns/1ns
module lock_link_checker
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic spi_sel_n_in,
  input wire logic buffer_release_try_in,
  input wire logic [63:0] lane_arrival_in,
  input wire logic link_digital_hold_out,
  input wire logic outside_vref_select_out,
  input wire logic output_current_doubler_bit_out,
  input wire logic [63:0] lane_arrival_capture_out,
  input wire logic lane_arrival_valid_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  capture_take_a: assert property (
    buffer_release_try_in && !lane_arrival_valid_out && !link_digital_hold_out
    |=> lane_arrival_valid_out && lane_arrival_capture_out == $past(lane_arrival_in)) else $error("no capture");
  capture_keep_a: assert property (
    lane_arrival_valid_out && !link_digital_hold_out |=> $stable(lane_arrival_capture_out)) else $error("moved");
  attempt_ignored_a: assert property (
    lane_arrival_valid_out && buffer_release_try_in |=> lane_arrival_capture_out == $past(lane_arrival_capture_out))
    else $error("late capture");
  valid_stays_a: assert property (
    lane_arrival_valid_out && !link_digital_hold_out |=> lane_arrival_valid_out) else $error("valid lost");
  hold_clears_a: assert property (
    link_digital_hold_out |=> !lane_arrival_valid_out) else $error("valid in hold");
  valid_cause_a: assert property (
    $rose(lane_arrival_valid_out) |-> $past(buffer_release_try_in) && !$past(link_digital_hold_out))
    else $error("bad capture");
  reset_outputs_a: assert property (
    $fell(reset_in) |-> !link_digital_hold_out && !outside_vref_select_out && !lane_arrival_valid_out)
    else $error("reset value");
  regs_idle_a: assert property (
    spi_sel_n_in [*8] |-> $stable(link_digital_hold_out) && $stable(outside_vref_select_out)
    && $stable(output_current_doubler_bit_out)) else $error("write without frame");
endmodule
bind lock_link_regs lock_link_checker chk (.clock_in(clock_in), .reset_in(reset_in),
  .spi_sel_n_in(spi_sel_n_in), .buffer_release_try_in(buffer_release_try_in),
  .lane_arrival_in(lane_arrival_in), .link_digital_hold_out(link_digital_hold_out),
  .outside_vref_select_out(outside_vref_select_out),
  .output_current_doubler_bit_out(output_current_doubler_bit_out),
  .lane_arrival_capture_out(lane_arrival_capture_out), .lane_arrival_valid_out(lane_arrival_valid_out));

// ### bench/serdes_lock_and_link_reset_regs_tb.sv
/* self-checking bench for lock_link_regs
   bit-bangs the serial port, 10 clock_in cycles high and 11 low per serial clock period */
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t bad value", $time); end end
module serdes_lock_and_link_reset_regs_tb;
  import lock_regs_pkg::*;
  logic clock_in = 0, reset_in = 1, sck = 0, sel_n = 1, sdi = 0, tr = 0, sdo, oe, hold, vref, dbl, valid;
  logic [3:0] lock = 4'hF, p;
  logic [63:0] arr = '0, cap, a1;
  logic [7:0] r = 8'h39, q;
  logic [14:0] ad [3] = '{ADDR_LINK_RESET, ADDR_VREF_SELECT, ADDR_CUR_DOUBLER};
  int fail_count = 0, checks = 0, cyc = 0;
  logic glitch = 0;
  always #20 clock_in = ~clock_in;
  lock_link_regs dut (.clock_in(clock_in), .reset_in(reset_in), .spi_clk_in(sck), .spi_sel_n_in(sel_n),
    .spi_data_in(sdi), .spi_data_out(sdo), .spi_data_oe_out(oe), .serdes_lock_live_in(lock),
    .buffer_release_try_in(tr), .lane_arrival_in(arr), .link_digital_hold_out(hold),
    .outside_vref_select_out(vref), .output_current_doubler_bit_out(dbl),
    .lane_arrival_capture_out(cap), .lane_arrival_valid_out(valid));
  function automatic logic [7:0] nx(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task w(int n);
    repeat (n) @(posedge clock_in);
  endtask
  task xfer(logic rd, logic [14:0] a, logic [7:0] d);
    logic [23:0] f;
    f = {rd, a, d};
    @(posedge clock_in) sel_n <= 0;
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clock_in) sdi <= f[i];
      w(9);
      q[i % 8] = (i < 8) ? sdo : q[i % 8];
      if (rd && i < 8) `CHK(oe, 1'b1)
      // lock drops for two cycles so its last low cycle meets the write
      if (glitch && i == 0)
        lock <= 4'h0;
      @(posedge clock_in) sck <= 1;
      @(posedge clock_in);
      if (glitch && i == 0)
        lock <= 4'hF;
      w(8);
      @(posedge clock_in) sck <= 0;
    end
    w(9);
    @(posedge clock_in) sel_n <= 1;
    sdi <= ~sdi;
    w(10);
  endtask
  task rdc(logic [14:0] a, logic [7:0] e);
    xfer(1, a, 8'h00);
    `CHK(q, e)
  endtask
  task pulse(logic [63:0] a);
    @(posedge clock_in)
    begin
      arr <= a;
      tr <= 1;
    end
    @(posedge clock_in) tr <= 0;
    w(1);
  endtask
  task setlock(logic [3:0] v);
    @(posedge clock_in) lock <= v;
    w(20);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 50000)
    begin
      fail_count++;
      finish_test;
    end
  end
  initial
  begin
    w(3);
    reset_in <= 0;
    w(5);
    rdc(ADDR_LOCK_STATUS, 8'hF0);
    xfer(0, ADDR_LOCK_STATUS, 8'h0F);
    rdc(ADDR_LOCK_STATUS, 8'hF0);
    for (int j = 0; j < 3; j++)
      rdc(ad[j], REG_RESET);
    for (int k = 0; k < 6; k++)
    begin
      r = nx(r);
      p = (k == 0) ? 4'h0 : r[3:0];
      setlock(p);
      rdc(ADDR_LOCK_STATUS, {p, ~p});
      setlock(4'hF);
      rdc(ADDR_LOCK_STATUS, {4'hF, ~p});
      r = nx(r);
      xfer(0, ADDR_LOCK_STATUS, r);
      rdc(ADDR_LOCK_STATUS, {4'hF, ~p & ~r[3:0]});
      xfer(0, ADDR_LOCK_STATUS, 8'h0F);
    end
    setlock(4'h0);
    xfer(0, ADDR_LOCK_STATUS, 8'h0F);
    rdc(ADDR_LOCK_STATUS, 8'h0F);
    setlock(4'hF);
    xfer(0, ADDR_LOCK_STATUS, 8'h05);
    rdc(ADDR_LOCK_STATUS, 8'hFA);
    xfer(0, ADDR_LOCK_STATUS, 8'h0F);
    glitch = 1;
    xfer(0, ADDR_LOCK_STATUS, 8'h0F);
    glitch = 0;
    rdc(ADDR_LOCK_STATUS, 8'hFF);
    for (int j = 0; j < 6; j++)
    begin
      r = nx(r);
      xfer(0, ad[j % 3], r);
      rdc(ad[j % 3], r);
      `CHK(j % 3 == 0 ? hold : j % 3 == 1 ? vref : dbl, r[0])
    end
    xfer(0, 15'h0251, 8'hFF);
    rdc(15'h0251, UNMAPPED_READ);
    xfer(0, ADDR_LINK_RESET, 8'h01);
    r = nx(r);
    pulse({8{r}});
    `CHK(valid, 1'b0)
    xfer(0, ADDR_LINK_RESET, 8'h00);
    r = nx(r);
    a1 = {8{r}};
    pulse(a1);
    `CHK({valid, cap}, {1'b1, a1})
    pulse(~a1);
    `CHK(cap, a1)
    xfer(0, ADDR_LINK_RESET, 8'h01);
    `CHK(valid, 1'b0)
    xfer(0, ADDR_LINK_RESET, 8'h00);
    pulse(~a1);
    `CHK(cap, ~a1)
    finish_test;
  end
endmodule
